// *** verif/csi2_lane_receiver_tb_top.sv ***
`timescale 1ns/10ps
`include "csi_rx_regs.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
// ----
// Receiver bench
// ----
module csi2_lane_receiver_tb_top;
	logic clk_in, reset_in, link_clk, cont_clk_in, hs_valid, pay_ready_in, full_seen;
	logic [4:0] lp_dp, lp_dn, lane_hs_out, term_en_out;
	logic [1:0] lane_cfg_in, hdr_vc_out;
	logic [31:0] hs_data;
	logic link_ready_out, hdr_valid_out, hdr_short_out, pay_valid_out, pay_last_out, crc_valid_out;
	logic [5:0] hdr_dt_out;
	logic [15:0] hdr_wc_out, crc_out;
	logic [7:0] hdr_ecc_out, pay_data_out;
	logic [32:0] hq[$];
	logic [8:0] pq[$];
	logic [15:0] cq[$];
	int fails, n_checks, rmode;
	csi_rx_top dut_u (.clk_in, .reset_in, .link_clk_in(link_clk), .lp_dp_in(lp_dp), .lp_dn_in(lp_dn), .lane_cfg_in,
		.cont_clk_in, .hs_data_in(hs_data), .hs_valid_in(hs_valid), .link_ready_out, .lane_hs_out, .term_en_out,
		.hdr_valid_out, .hdr_vc_out, .hdr_dt_out, .hdr_wc_out, .hdr_ecc_out, .hdr_short_out, .pay_data_out,
		.pay_valid_out, .pay_last_out, .pay_ready_in, .crc_out, .crc_valid_out);
	csi_sensor_model sm_u (.clk_in, .link_clk_out(link_clk), .lp_dp_out(lp_dp), .lp_dn_out(lp_dn),
		.hs_data_out(hs_data), .hs_valid_out(hs_valid));
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	// Collect outputs; consumer is ready, toggling or stalled
	always @(posedge clk_in) begin
		if (hdr_valid_out) hq.push_back({hdr_vc_out, hdr_dt_out, hdr_wc_out, hdr_ecc_out, hdr_short_out});
		if (pay_valid_out && pay_ready_in) pq.push_back({pay_last_out, pay_data_out});
		if (crc_valid_out) cq.push_back(crc_out);
		if (link_ready_out === 1'b0) full_seen = 1'b1;
	end
	always @(negedge clk_in) pay_ready_in <= (rmode == 0) || (rmode == 1 && !pay_ready_in);
	task give_verdict;
		if (fails == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	task await(input int h, input int c, input int p);
		for (int i = 0; i < 3000 && (hq.size() < h || cq.size() < c || pq.size() < p); i++) @(negedge clk_in);
		if (hq.size() < h || cq.size() < c || pq.size() < p) begin
			fails++;
			give_verdict;
		end
	endtask : await
	// All lanes and clock lane enter; only configured lanes may follow
	task burst(input logic [1:0] c, input logic [7:0] b[$]);
		logic [4:0] m;
		m = 5'h10 | ((5'h1 << (1 << c)) - 5'h1);
		lane_cfg_in = c;
		hq.delete();
		pq.delete();
		cq.delete();
		sm_u.enter(5'h1f);
		`CHK(lane_hs_out, m)
		`CHK(term_en_out, m)
		sm_u.send(b, 1 << c);
	endtask : burst
	task done;
		sm_u.leave(5'h1f);
		`CHK(lane_hs_out, 5'h00)
		`CHK(term_en_out, 5'h00)
	endtask : done
	task t_refuse;
		sm_u.lp(5'h01, `CSI_LP_HSRQ, 8);
		sm_u.lp(5'h01, `CSI_LP_STOP, 8);
		sm_u.lp(5'h01, `CSI_LP_BRIDGE, 20);
		`CHK(lane_hs_out, 5'h00)
		sm_u.lp(5'h01, `CSI_LP_STOP, 8);
	endtask : t_refuse
	task t_short;
		logic [7:0] di [3] = '{8'h40, 8'h81, 8'h0f};
		logic [7:0] q[$];
		for (int c = 0; c < 3; c++) begin
			q = {di[c], 8'h34, 8'h12, 8'h5a};
			burst(c[1:0], q);
			await(1, 0, 0);
			`CHK(hq[0], {di[c], 16'h1234, 8'h5a, 1'b1})
			done;
		end
	endtask : t_short
	// Data type just past the short range, consumer toggling
	task t_long;
		logic [7:0] q[$];
		q = {8'h10, 8'h05, 8'h00, 8'h3c, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'hef, 8'hbe, 8'h00};
		rmode = 1;
		burst(2'h2, q);
		await(1, 1, 5);
		`CHK(hq[0], {8'h10, 16'h0005, 8'h3c, 1'b0})
		for (int i = 0; i < 5; i++) `CHK(pq[i], {i == 4, 8'h11 + i[7:0]})
		`CHK(cq[0], 16'hbeef)
		done;
	endtask : t_long
	// Stalled consumer: FIFO fills and refuses, then drains
	task t_full;
		logic [7:0] q[$];
		for (int i = 0; i < 86; i++) q.push_back(i[7:0]);
		q[0] = 8'h2b;
		q[1] = 8'h50;
		rmode = 2;
		full_seen = 1'b0;
		burst(2'h0, q);
		`CHK(full_seen, 1'b1)
		rmode = 0;
		await(1, 0, 4);
		`CHK(hq[0], {8'h2b, 16'h0250, 8'h03, 1'b0})
		`CHK(pq[0], {1'b0, 8'h04})
		// Read pointer needs a few link clock edges to reach the write side
		repeat (40) @(negedge clk_in);
		`CHK(link_ready_out, 1'b1)
		done;
	endtask : t_full
	task t_cont;
		cont_clk_in = 1'b1;
		sm_u.enter(5'h11);
		sm_u.leave(5'h01);
		`CHK(lane_hs_out, 5'h10)
		sm_u.lp(5'h10, `CSI_LP_STOP, 20);
		`CHK(lane_hs_out[4], 1'b1)
		cont_clk_in = 1'b0;
		sm_u.lp(5'h10, `CSI_LP_STOP, 8);
		`CHK(lane_hs_out[4], 1'b0)
	endtask : t_cont
	// Short reset; the design stretches it for the link side
	initial begin
		reset_in = 1'b1;
		lane_cfg_in = 2'h0;
		cont_clk_in = 1'b0;
		pay_ready_in = 1'b1;
		rmode = 0;
		fails = 0;
		n_checks = 0;
		full_seen = 1'b0;
		repeat (5) @(negedge clk_in);
		reset_in = 1'b0;
		`CHK(lane_hs_out, 5'h00)
		`CHK(term_en_out, 5'h00)
		// Link clock runs on until the stretched reset has landed there
		repeat (75) @(negedge clk_in);
		sm_u.run = 1'b0;
		t_refuse;
		t_short;
		t_long;
		t_full;
		t_cont;
		give_verdict;
	end
endmodule : csi2_lane_receiver_tb_top

// *** verif/csi_rx_monitor.sv ***
`timescale 1ns/10ps
`include "csi_rx_regs.svh"
// ----
// Lane mode and packet checks
// ----
module csi_rx_monitor (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [`CSI_NLANE-1:0] lp_dp_in,
	input wire logic [`CSI_NLANE-1:0] lp_dn_in,
	input wire logic [1:0] lane_cfg_in,
	input wire logic cont_clk_in,
	input wire logic [`CSI_NLANE-1:0] lane_hs_out,
	input wire logic [`CSI_NLANE-1:0] term_en_out,
	input wire logic hdr_valid_out,
	input wire logic [5:0] hdr_dt_out,
	input wire logic hdr_short_out,
	input wire logic [7:0] pay_data_out,
	input wire logic pay_valid_out,
	input wire logic pay_ready_in,
	input wire logic crc_valid_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (reset_in);
	logic [2:0] zc_reg;
	logic [2:0] zc_next;
	// Edges lane 0 pins have sat at LP-00, saturating; entry needs a settled bridge state
	assign zc_next = (lp_dp_in[0] | lp_dn_in[0]) ? 3'h0 : ((zc_reg == 3'h7) ? zc_reg : zc_reg + 3'h1);
	always_ff @(posedge clk_in) zc_reg <= reset_in ? 3'h0 : zc_next;
	property p_term;
		term_en_out == lane_hs_out && (!term_en_out[0] || $past(!lp_dp_in[0] && !lp_dn_in[0], 5));
	endproperty
	a_term: assert property (p_term) else $error("termination differs from lane mode");
	property p_entry; $rose(lane_hs_out[0]) |-> zc_reg >= 3'h3; endproperty
	a_entry: assert property (p_entry) else $error("high speed without bridge state");
	property p_keep; lane_hs_out[0] && !lp_dp_in[0] && !lp_dn_in[0] |=> lane_hs_out[0]; endproperty
	a_keep: assert property (p_keep) else $error("lane left high speed early");
	property p_exit; (lp_dp_in[0] && lp_dn_in[0])[*8] |-> !lane_hs_out[0]; endproperty
	a_exit: assert property (p_exit) else $error("stop state ignored");
	property p_cont; cont_clk_in && lane_hs_out[4] |=> lane_hs_out[4]; endproperty
	a_cont: assert property (p_cont) else $error("continuous clock lane dropped");
	property p_cfg; lane_cfg_in == `CSI_CFG_1LANE |-> lane_hs_out[3:1] == 3'h0; endproperty
	a_cfg: assert property (p_cfg) else $error("unused lane active");
	property p_rst; disable iff (1'b0) reset_in |=> lane_hs_out == 5'h00 && !hdr_valid_out; endproperty
	a_rst: assert property (p_rst) else $error("lane active after reset");
	property p_hdr; hdr_valid_out |-> hdr_short_out == (hdr_dt_out <= `CSI_DT_SHORT_MAX); endproperty
	a_hdr: assert property (p_hdr) else $error("packet class wrong");
	property p_pulse; hdr_valid_out |=> !hdr_valid_out; endproperty
	a_pulse: assert property (p_pulse) else $error("header pulse too long");
	property p_pay; pay_valid_out && !pay_ready_in |=> pay_valid_out && $stable(pay_data_out); endproperty
	a_pay: assert property (p_pay) else $error("payload byte lost in stall");
	property p_crc; crc_valid_out |=> !crc_valid_out; endproperty
	a_crc: assert property (p_crc) else $error("checksum pulse too long");
	c_short: cover property (hdr_valid_out && hdr_short_out);
	c_long: cover property (hdr_valid_out && !hdr_short_out);
	c_stall: cover property (pay_valid_out && !pay_ready_in);
endmodule : csi_rx_monitor

bind csi_rx_top csi_rx_monitor mon_u (.clk_in, .reset_in, .lp_dp_in, .lp_dn_in, .lane_cfg_in, .cont_clk_in,
	.lane_hs_out, .term_en_out, .hdr_valid_out, .hdr_dt_out, .hdr_short_out, .pay_data_out, .pay_valid_out,
	.pay_ready_in, .crc_valid_out);

// *** verif/csi_sensor_model.sv ***
`timescale 1ns/10ps
`include "csi_rx_regs.svh"
// ----
// Image sensor transmitter
// ----
module csi_sensor_model (
	input wire logic clk_in,
	output logic link_clk_out,
	output logic [`CSI_NLANE-1:0] lp_dp_out,
	output logic [`CSI_NLANE-1:0] lp_dn_out,
	output logic [`CSI_DATA_W-1:0] hs_data_out,
	output logic hs_valid_out
);
	logic run;
	// Byte clock runs in reset and bursts only; stands still between frames
	initial begin
		run = 1'b1;
		lp_dp_out = 5'h1f;
		lp_dn_out = 5'h1f;
		hs_data_out = 32'h0;
		hs_valid_out = 1'b0;
		link_clk_out = 1'b0;
		#37;
		forever #80 link_clk_out = run ? ~link_clk_out : 1'b0;
	end
	task lp(input logic [4:0] m, input logic [1:0] c, input int n);
		@(negedge clk_in);
		lp_dp_out = (lp_dp_out & ~m) | (m & {5{c[1]}});
		lp_dn_out = (lp_dn_out & ~m) | (m & {5{c[0]}});
		repeat (n) @(negedge clk_in);
	endtask : lp
	// Stop, request, bridge; bridge held through the burst
	task enter(input logic [4:0] m);
		run = 1'b1;
		lp(m, `CSI_LP_STOP, 8);
		lp(m, `CSI_LP_HSRQ, 8);
		lp(m, `CSI_LP_BRIDGE, 40);
	endtask : enter
	// Lane 0 byte first in each word
	task send(input logic [7:0] b[$], input int nl);
		for (int i = 0; i < b.size(); i += nl) begin
			@(negedge link_clk_out);
			for (int k = 0; k < nl; k++) hs_data_out[8*k+:8] = b[i+k];
			hs_valid_out = 1'b1;
		end
		@(negedge link_clk_out);
		hs_valid_out = 1'b0;
		hs_data_out = ~hs_data_out; // Released bus must not look valid
	endtask : send
	task leave(input logic [4:0] m);
		lp(m, `CSI_LP_STOP, 20);
		run = 1'b0;
	endtask : leave
endmodule : csi_sensor_model

// *** verilog/csi_fifo.sv ***
`timescale 1ns/10ps

// Two-clock FIFO with gray-coded pointers
module csi_fifo #(
	parameter int WIDTH = 35,
	parameter int DEPTH = 8
) (
	input wire logic wr_clk_in,
	input wire logic wr_rst_in,
	input wire logic rd_clk_in,
	input wire logic rd_rst_in,
	csi_stream_if.snk wr,
	csi_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);

	function automatic logic [AW:0] csi_gray(input logic [AW:0] b);
		csi_gray = b ^ (b >> 1);
	endfunction : csi_gray

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0] wbin_reg, wgray_reg, rbin_reg, rgray_reg;
	logic [AW:0] rg_meta, rg_sync, wg_meta, wg_sync;

	// ------------------------------------------------------------
	// Status and handshakes
	// ------------------------------------------------------------
	wire push = wr.valid && wr.ready;
	wire pop = rd.valid && rd.ready;
	wire [AW:0] wbin_next = wbin_reg + {{AW{1'b0}}, push};
	wire [AW:0] rbin_next = rbin_reg + {{AW{1'b0}}, pop};
	// Full is pessimistic while the read pointer is in flight
	wire full = wgray_reg == {~rg_sync[AW:AW-1], rg_sync[AW-2:0]};
	assign wr.ready = !full;
	assign rd.valid = rgray_reg != wg_sync;
	assign rd.data = mem_reg[rbin_reg[AW-1:0]];

	// Write side, link clock
	always_ff @(posedge wr_clk_in) begin
		if (push)
			mem_reg[wbin_reg[AW-1:0]] <= wr.data;
		rg_meta <= rgray_reg;
		rg_sync <= rg_meta;
		if (wr_rst_in) begin
			wbin_reg <= '0;
			wgray_reg <= '0;
		end else begin
			wbin_reg <= wbin_next;
			wgray_reg <= csi_gray(wbin_next);
		end
	end

	// Read side, core clock
	always_ff @(posedge rd_clk_in) begin
		wg_meta <= wgray_reg;
		wg_sync <= wg_meta;
		if (rd_rst_in) begin
			rbin_reg <= '0;
			rgray_reg <= '0;
		end else begin
			rbin_reg <= rbin_next;
			rgray_reg <= csi_gray(rbin_next);
		end
	end
endmodule : csi_fifo

// *** verilog/csi_pkg.sv ***
`include "csi_rx_regs.svh"

package csi_pkg;

	// ------------------------------------------------------------
	// Lane and packet states, one-hot
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		LN_STOP = 3'h1,
		LN_HSRQ = 3'h2,
		LN_HS = 3'h4
	} csi_lane_t;

	typedef enum logic [2:0] {
		PK_HDR = 3'h1,
		PK_DATA = 3'h2,
		PK_CRC = 3'h4
	} csi_pkt_t;

	typedef logic [`CSI_WORD_W-1:0] csi_word_t;

endpackage : csi_pkg

// *** verilog/csi_rx_regs.svh ***
`ifndef CSI_RX_REGS_SVH
`define CSI_RX_REGS_SVH

// ------------------------------------------------------------
// Low-power line codes, {dp, dn}
// ------------------------------------------------------------
`define CSI_LP_STOP 2'b11
`define CSI_LP_HSRQ 2'b01
`define CSI_LP_BRIDGE 2'b00

// ------------------------------------------------------------
// Lanes and lane configuration codes
// ------------------------------------------------------------
`define CSI_NLANE 5
`define CSI_CLK_LANE 4
`define CSI_CFG_1LANE 2'h0
`define CSI_CFG_2LANE 2'h1
`define CSI_CFG_4LANE 2'h2
`define CSI_SYNC_W 13
`define CSI_LSYNC_W 4
`define CSI_LRST_HOLD 6'h30

// ------------------------------------------------------------
// Packet layout
// ------------------------------------------------------------
`define CSI_DT_SHORT_MAX 6'h0f
`define CSI_HDR_DI 16'h0000
`define CSI_HDR_WCL 16'h0001
`define CSI_HDR_WCH 16'h0002
`define CSI_VC_LSB 6
`define CSI_DT_W 6

// ------------------------------------------------------------
// Lane word carried through the FIFO: {byte count, 4 bytes}
// ------------------------------------------------------------
`define CSI_DATA_W 32
`define CSI_NB_W 3
`define CSI_WORD_W 35
`define CSI_FIFO_DEPTH 8

`endif

// *** verilog/csi_rx_top.sv ***
`timescale 1ns/10ps
`include "csi_rx_regs.svh"
// ------------------------------------------------------------
// ------------------------------------------------------------
module csi_rx_top
	import csi_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic link_clk_in,
	input wire logic [`CSI_NLANE-1:0] lp_dp_in,
	input wire logic [`CSI_NLANE-1:0] lp_dn_in,
	input wire logic [1:0] lane_cfg_in,
	input wire logic cont_clk_in,
	input wire logic [`CSI_DATA_W-1:0] hs_data_in,
	input wire logic hs_valid_in,
	output logic link_ready_out,
	output logic [`CSI_NLANE-1:0] lane_hs_out,
	output logic [`CSI_NLANE-1:0] term_en_out,
	output logic hdr_valid_out,
	output logic [1:0] hdr_vc_out,
	output logic [5:0] hdr_dt_out,
	output logic [15:0] hdr_wc_out,
	output logic [7:0] hdr_ecc_out,
	output logic hdr_short_out,
	output logic [7:0] pay_data_out,
	output logic pay_valid_out,
	output logic pay_last_out,
	input wire logic pay_ready_in,
	output logic [15:0] crc_out,
	output logic crc_valid_out
);

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------
	// Byte count per lane word for the lane configuration
	function automatic logic [`CSI_NB_W-1:0] lane_bytes(input logic [1:0] cfg);
		if (cfg == `CSI_CFG_4LANE)
			lane_bytes = 3'h4;
		else if (cfg == `CSI_CFG_2LANE)
			lane_bytes = 3'h2;
		else
			lane_bytes = 3'h1;
	endfunction : lane_bytes

	// Low-power state walk; escape codes are simply not recognised
	function automatic csi_lane_t lane_next(input csi_lane_t st, input logic [1:0] lp,
		input logic hold);
		case (st)
			LN_STOP: lane_next = (lp == `CSI_LP_HSRQ) ? LN_HSRQ : LN_STOP;
			LN_HSRQ: begin
				if (lp == `CSI_LP_BRIDGE)
					lane_next = LN_HS;
				else if (lp == `CSI_LP_HSRQ)
					lane_next = LN_HSRQ;
				else
					lane_next = LN_STOP;
			end
			LN_HS: lane_next = (lp == `CSI_LP_STOP && !hold) ? LN_STOP : LN_HS;
			default: lane_next = LN_STOP;
		endcase
	endfunction : lane_next

	// ------------------------------------------------------------
	// Pin synchronisers, core clock
	// ------------------------------------------------------------
	logic [`CSI_SYNC_W-1:0] ps1_reg, ps2_reg, ps3_reg, pf_reg;
	wire [`CSI_SYNC_W-1:0] pin_raw = {cont_clk_in, lane_cfg_in, lp_dp_in, lp_dn_in};
	// A bit moves only once the second and third stages agree
	wire [`CSI_SYNC_W-1:0] pf_next = (ps2_reg & ps3_reg) | (pf_reg & (ps2_reg | ps3_reg));

	always_ff @(posedge clk_in) begin
		ps1_reg <= pin_raw;
		ps2_reg <= ps1_reg;
		ps3_reg <= ps2_reg;
		pf_reg <= pf_next;
	end

	wire [`CSI_NLANE-1:0] dn_f = pf_reg[`CSI_NLANE-1:0];
	wire [`CSI_NLANE-1:0] dp_f = pf_reg[2*`CSI_NLANE-1:`CSI_NLANE];
	wire [1:0] cfg_f = pf_reg[2*`CSI_NLANE+1:2*`CSI_NLANE];
	wire cont_f = pf_reg[`CSI_SYNC_W-1];
	wire [`CSI_NB_W-1:0] nbytes = lane_bytes(cfg_f);

	// ------------------------------------------------------------
	// Lane state machines, clock lane is the last one
	// ------------------------------------------------------------
	csi_lane_t lane_reg [`CSI_NLANE];
	csi_lane_t lane_next_v [`CSI_NLANE];
	logic [`CSI_NLANE-1:0] lane_on;

	genvar gi;
	generate
		for (gi = 0; gi < `CSI_NLANE; gi++) begin : g_lane
			// Unused data lanes are parked in stop
			if (gi == `CSI_CLK_LANE)
				assign lane_on[gi] = 1'b1;
			else
				assign lane_on[gi] = gi < nbytes;
			assign lane_next_v[gi] = lane_on[gi]
				? lane_next(lane_reg[gi], {dp_f[gi], dn_f[gi]},
					gi == `CSI_CLK_LANE && cont_f)
				: LN_STOP;
			always_ff @(posedge clk_in) begin
				if (reset_in)
					lane_reg[gi] <= LN_STOP;
				else
					lane_reg[gi] <= lane_next_v[gi];
			end
			// Receive-only: termination is the only thing driven at the lane
			assign term_en_out[gi] = lane_reg[gi] == LN_HS;
			assign lane_hs_out[gi] = lane_reg[gi] == LN_HS;
		end
	endgenerate

	// ------------------------------------------------------------
	// Link clock side: reset, config and burst state cross over
	// ------------------------------------------------------------
	// Reset stretched so a short pulse still spans several link clock edges
	logic [5:0] rsth_reg;
	wire hold_rst = reset_in || rsth_reg != 6'h0;
	always_ff @(posedge clk_in) begin
		if (reset_in)
			rsth_reg <= `CSI_LRST_HOLD;
		else if (rsth_reg != 6'h0)
			rsth_reg <= rsth_reg - 6'h1;
	end
	logic [`CSI_LSYNC_W-1:0] ls1_reg, ls2_reg, ls3_reg, lf_reg;
	wire [`CSI_LSYNC_W-1:0] link_raw = {hold_rst, cfg_f, lane_hs_out[0]};
	wire [`CSI_LSYNC_W-1:0] lf_next = (ls2_reg & ls3_reg) | (lf_reg & (ls2_reg | ls3_reg));

	// Link clock may stop, so the link reset only lands while it runs
	always_ff @(posedge link_clk_in) begin
		ls1_reg <= link_raw;
		ls2_reg <= ls1_reg;
		ls3_reg <= ls2_reg;
		lf_reg <= lf_next;
	end

	wire link_rst = lf_reg[`CSI_LSYNC_W-1];
	wire link_hs = lf_reg[0];
	wire [`CSI_NB_W-1:0] link_nb = lane_bytes(lf_reg[2:1]);

	csi_stream_if wr_if();
	csi_stream_if rd_if();

	// Lane 0 byte lands in the low byte, so it is read out first
	assign wr_if.data = {link_nb, hs_data_in};
	assign wr_if.valid = hs_valid_in && link_hs && !link_rst;
	assign link_ready_out = wr_if.ready;

	csi_fifo #(
		.WIDTH(`CSI_WORD_W),
		.DEPTH(`CSI_FIFO_DEPTH)
	) u_fifo (
		.wr_clk_in(link_clk_in),
		.wr_rst_in(link_rst),
		.rd_clk_in(clk_in),
		.rd_rst_in(hold_rst),
		.wr(wr_if.snk),
		.rd(rd_if.src)
	);

	// ------------------------------------------------------------
	// Packet parser, core clock
	// ------------------------------------------------------------
	csi_pkt_t pk_reg, pk_next;
	logic [15:0] cnt_reg, cnt_next;
	logic [1:0] idx_reg, idx_next;
	logic [7:0] di_reg, di_next;
	logic [15:0] wc_reg, wc_next;
	logic [7:0] ecc_reg, ecc_next;
	logic [15:0] crc_reg, crc_next;
	logic [7:0] pay_reg, pay_next;
	logic hdrv_reg, hdrv_next, crcv_reg, crcv_next;
	logic payv_reg, payv_next, payl_reg, payl_next;
	logic hs0_reg;
	logic pkt_end;

	wire [`CSI_NB_W-1:0] word_nb = rd_if.data[`CSI_WORD_W-1:`CSI_DATA_W];
	wire [7:0] cur_byte = rd_if.data[{idx_reg, 3'h0} +: 8];
	wire last_in_word = ({1'b0, idx_reg} + 3'h1) >= word_nb;
	// Payload waits for the consumer; this is what lets the FIFO fill
	wire take = rd_if.valid && (pk_reg != PK_DATA || !payv_reg || pay_ready_in);
	wire is_short = di_reg[`CSI_DT_W-1:0] <= `CSI_DT_SHORT_MAX;
	wire burst_end = hs0_reg && !lane_hs_out[0];
	// Packets start on lane 0, so bytes after a packet end are filler
	assign rd_if.ready = take && (last_in_word || pkt_end);

	// Next-state decode for header, payload and checksum
	always_comb begin
		pk_next = pk_reg;
		cnt_next = cnt_reg;
		idx_next = idx_reg;
		di_next = di_reg;
		wc_next = wc_reg;
		ecc_next = ecc_reg;
		crc_next = crc_reg;
		pay_next = pay_reg;
		payv_next = payv_reg && !pay_ready_in;
		payl_next = payl_reg;
		hdrv_next = 1'b0;
		crcv_next = 1'b0;
		pkt_end = 1'b0;
		if (take) begin
			cnt_next = cnt_reg + 16'h1;
			case (pk_reg)
				PK_HDR: begin
					if (cnt_reg == `CSI_HDR_DI)
						di_next = cur_byte;
					else if (cnt_reg == `CSI_HDR_WCL)
						wc_next[7:0] = cur_byte;
					else if (cnt_reg == `CSI_HDR_WCH)
						wc_next[15:8] = cur_byte;
					else begin
						ecc_next = cur_byte;
						hdrv_next = 1'b1;
						cnt_next = 16'h0;
						if (is_short)
							pkt_end = 1'b1;
						else if (wc_reg == 16'h0)
							pk_next = PK_CRC;
						else
							pk_next = PK_DATA;
					end
				end
				PK_DATA: begin
					pay_next = cur_byte;
					payv_next = 1'b1;
					payl_next = cnt_next == wc_reg;
					if (cnt_next == wc_reg) begin
						pk_next = PK_CRC;
						cnt_next = 16'h0;
					end
				end
				PK_CRC: begin
					if (cnt_reg == 16'h0)
						crc_next[7:0] = cur_byte;
					else begin
						crc_next[15:8] = cur_byte;
						crcv_next = 1'b1;
						pkt_end = 1'b1;
					end
				end
				default: pk_next = PK_HDR;
			endcase
			if (pkt_end) begin
				pk_next = PK_HDR;
				cnt_next = 16'h0;
			end
			idx_next = (last_in_word || pkt_end) ? 2'h0 : idx_reg + 2'h1;
		end
		// Return to stop always realigns on a fresh header
		if (burst_end) begin
			pk_next = PK_HDR;
			cnt_next = 16'h0;
			idx_next = 2'h0;
		end
	end

	// Parser state
	always_ff @(posedge clk_in) begin
		if (hold_rst) begin
			pk_reg <= PK_HDR;
			cnt_reg <= 16'h0;
			idx_reg <= 2'h0;
			hs0_reg <= 1'b0;
		end else begin
			pk_reg <= pk_next;
			cnt_reg <= cnt_next;
			idx_reg <= idx_next;
			hs0_reg <= lane_hs_out[0];
		end
	end

	// Header, payload and checksum outputs
	always_ff @(posedge clk_in) begin
		if (hold_rst) begin
			di_reg <= 8'h0;
			wc_reg <= 16'h0;
			ecc_reg <= 8'h0;
			crc_reg <= 16'h0;
			pay_reg <= 8'h0;
			payv_reg <= 1'b0;
			payl_reg <= 1'b0;
			hdrv_reg <= 1'b0;
			crcv_reg <= 1'b0;
		end else begin
			di_reg <= di_next;
			wc_reg <= wc_next;
			ecc_reg <= ecc_next;
			crc_reg <= crc_next;
			pay_reg <= pay_next;
			payv_reg <= payv_next;
			payl_reg <= payl_next;
			hdrv_reg <= hdrv_next;
			crcv_reg <= crcv_next;
		end
	end

	// Identifier split into channel and type
	assign hdr_vc_out = di_reg[7:`CSI_VC_LSB];
	assign hdr_dt_out = di_reg[`CSI_DT_W-1:0];
	assign hdr_short_out = is_short;
	assign hdr_wc_out = wc_reg;
	assign hdr_ecc_out = ecc_reg;
	assign hdr_valid_out = hdrv_reg;
	assign pay_data_out = pay_reg;
	assign pay_valid_out = payv_reg;
	assign pay_last_out = payl_reg;
	assign crc_out = crc_reg;
	assign crc_valid_out = crcv_reg;

endmodule : csi_rx_top

// *** verilog/csi_stream_if.sv ***
`timescale 1ns/10ps
`include "csi_rx_regs.svh"

// Word stream between lane logic, FIFO and packet parser
interface csi_stream_if;
	logic [`CSI_WORD_W-1:0] data;
	logic valid;
	logic ready;
	modport src(output data, output valid, input ready);
	modport snk(input data, input valid, output ready);
endinterface : csi_stream_if
